/* pkg/pcer_pkg.sv */
/*
  Constants of the receive error report and bypass control block: register
  indices and byte addresses, field positions, reset values, error nibbles,
  interrupt layout and timing counts.
  Assumes a 200 MHz pclk and an APB master with 32-bit data.
*/
// How it works
// - read-only carrier integrity flag, resets to zero
// - indicator select 10 or 01 shows flag
// - code error: RX_ER, nibble 5h or 6h
// - premature end: RX_ER, nibble 4h or 6h
// - two IDLEs before end delimiter: premature end
// - link report bit: 3h with RX_ER, else pass
// - packet timeout report bit: 2h, else pass
// - top loopback bit ignores writes, reads zero
// - stretch bypass drives LEDs straight from status
// - codec bypass loads from strap, then writable
package pcer_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PCS_CFG = 8'h16;
  localparam logic [7:0] IDX_LOOP_BYP = 8'h17;
  localparam logic [7:0] IDX_PHY_CTL = 8'h19;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h1a;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h1b;
  localparam logic [11:0] ADDR_PCS_CFG = {2'h0, IDX_PCS_CFG, 2'h0};
  localparam logic [11:0] ADDR_LOOP_BYP = {2'h0, IDX_LOOP_BYP, 2'h0};
  localparam logic [11:0] ADDR_PHY_CTL = {2'h0, IDX_PHY_CTL, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STAT = {2'h0, IDX_IRQ_STAT, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};
  // pcs_config_status fields
  localparam int CIM_BIT = 4;
  localparam int CODE_SEL_BIT = 3;
  localparam int EARLY_SEL_BIT = 2;
  localparam int LINK_REP_BIT = 1;
  localparam int PKT_REP_BIT = 0;
  // loopback_bypass_control fields
  localparam int LBR_RSVD_BIT = 15;
  localparam int STRETCH_BYP_BIT = 14;
  localparam int CODEC_BYP_BIT = 13;
  // phy_control_reg indicator select field
  localparam int SEL_HI = 8;
  localparam int SEL_LO = 7;
  localparam logic [1:0] SEL_CIM_A = 2'h2;
  localparam logic [1:0] SEL_CIM_B = 2'h1;
  localparam logic [1:0] RST_SEL = 2'h0;
  localparam logic RST_CTL_BIT = 1'b0;
  // error nibbles placed on rxd
  localparam logic [3:0] NIB_CODE = 4'h5;
  localparam logic [3:0] NIB_EARLY = 4'h4;
  localparam logic [3:0] NIB_GENERIC = 4'h6;
  localparam logic [3:0] NIB_LINK = 4'h3;
  localparam logic [3:0] NIB_PKT = 4'h2;
  // interrupt status and mask layout
  localparam int IRQ_W = 5;
  localparam int IRQ_CODE = 0;
  localparam int IRQ_EARLY = 1;
  localparam int IRQ_LINK = 2;
  localparam int IRQ_PKT = 3;
  localparam int IRQ_CIM = 4;
  localparam logic [IRQ_W-1:0] RST_IRQ = 5'h00;
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int LED_STRETCH_NS = 20000;
  localparam int LED_STRETCH_CYC = (LED_STRETCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STRETCH_W = 12;
  localparam int NUM_LEDS = 2;
  // the synchroniser output is trustworthy only after its fourth edge
  localparam logic [2:0] STRAP_SETTLE_CYC = 3'h4;
  // strap capture sequence after reset
  typedef enum logic [1:0] {
    BOOT_WAIT = 2'b01,
    BOOT_RUN = 2'b10
  } pcer_boot_e;
endpackage : pcer_pkg

/* rtl/pcer_sync.sv */
/*
  Three-flop input synchroniser with agreement filter.
  Assumes the input is asynchronous to pclk; the output changes only when
  the second and third flops agree.
*/
`timescale 1ns/1ps
`default_nettype none
module pcer_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta;
  logic stage2;
  logic stage3;

  // first flop feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      meta <= async_in;
      stage2 <= meta;
      stage3 <= stage2;
    end
  end

  // accept a new level only once two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_out <= 1'b0;
    end else if (stage2 == stage3) begin
      sync_out <= stage3;
    end
  end
endmodule : pcer_sync
`default_nettype wire

/* rtl/pcer_top.sv */
/*
  Receive error report and bypass control: APB registers, 100 Mb/s receive
  nibble error substitution toward the MAC, carrier integrity flag, LED
  stretching and the strap-loaded codec bypass.
  Assumes the decoder flags (code error, idle, delimiter, link, timeout) come
  from logic on pclk, one nibble per rx_nibble_valid_in strobe.
*/
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pcer_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic speed_100_in,
  input wire logic rx_nibble_valid_in,
  input wire logic [3:0] rxd_in,
  input wire logic in_stream_in,
  input wire logic idle_sym_in,
  input wire logic end_delim_in,
  input wire logic code_err_in,
  input wire logic link_err_in,
  input wire logic pkt_timeout_in,
  input wire logic cim_unstable_in,
  input wire logic [pcer_pkg::NUM_LEDS-1:0] led_status_in,
  input wire logic symbol_strap_pin,
  output logic [3:0] rxd_out,
  output logic rx_er_out,
  output logic rx_valid_out,
  output logic transmit_indicator_pin,
  output logic rx_led_out,
  output logic nibble_codec_bypass,
  output logic irq
);
  import pcer_pkg::*;

  logic carrier_integrity_flag;
  logic code_violation_select;
  logic early_end_select;
  logic link_fault_report;
  logic packet_timeout_report;
  logic led_stretch_bypass;
  logic [1:0] indicator_select_field;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_events;
  logic [31:0] rd_word;
  logic idle_prev;
  logic delim_seen;
  logic early_end_err;
  logic strap_sync;
  logic [2:0] settle_cnt;
  pcer_boot_e boot_state;
  logic [NUM_LEDS-1:0] led_drive;
  logic setup_phase;
  logic wr_acc;

  function automatic logic reg_mapped(input logic [11:0] a);
    return (a == ADDR_PCS_CFG) || (a == ADDR_LOOP_BYP) || (a == ADDR_PHY_CTL) ||
           (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_MASK);
  endfunction : reg_mapped

  assign setup_phase = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite && reg_mapped(paddr);

  // strap pin is asynchronous to pclk
  pcer_sync u_strap_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(symbol_strap_pin),
    .sync_out(strap_sync)
  );

  // one wait-free answer: pready rises the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase && !reg_mapped(paddr);
      if (setup_phase) begin
        prdata <= rd_word;
      end
    end
  end

  // read mux; unimplemented and reserved bits read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (paddr)
      ADDR_PCS_CFG: begin
        rd_word[CIM_BIT] = carrier_integrity_flag;
        rd_word[CODE_SEL_BIT] = code_violation_select;
        rd_word[EARLY_SEL_BIT] = early_end_select;
        rd_word[LINK_REP_BIT] = link_fault_report;
        rd_word[PKT_REP_BIT] = packet_timeout_report;
      end
      ADDR_LOOP_BYP: begin
        rd_word[LBR_RSVD_BIT] = 1'b0;
        rd_word[STRETCH_BYP_BIT] = led_stretch_bypass;
        rd_word[CODEC_BYP_BIT] = nibble_codec_bypass;
      end
      ADDR_PHY_CTL: rd_word[SEL_HI:SEL_LO] = indicator_select_field;
      ADDR_IRQ_STAT: rd_word[IRQ_W-1:0] = irq_status;
      ADDR_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_violation_select <= RST_CTL_BIT;
      early_end_select <= RST_CTL_BIT;
      link_fault_report <= RST_CTL_BIT;
      packet_timeout_report <= RST_CTL_BIT;
      led_stretch_bypass <= RST_CTL_BIT;
      indicator_select_field <= RST_SEL;
      irq_mask <= RST_IRQ;
    end else if (wr_acc) begin
      if (paddr == ADDR_PCS_CFG) begin
        code_violation_select <= pwdata[CODE_SEL_BIT];
        early_end_select <= pwdata[EARLY_SEL_BIT];
        link_fault_report <= pwdata[LINK_REP_BIT];
        packet_timeout_report <= pwdata[PKT_REP_BIT];
      end
      if (paddr == ADDR_LOOP_BYP) begin
        led_stretch_bypass <= pwdata[STRETCH_BYP_BIT];
      end
      if (paddr == ADDR_PHY_CTL) begin
        indicator_select_field <= pwdata[SEL_HI:SEL_LO];
      end
      if (paddr == ADDR_IRQ_MASK) begin
        irq_mask <= pwdata[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_state <= BOOT_WAIT;
      settle_cnt <= 3'h0;
      nibble_codec_bypass <= RST_CTL_BIT;
    end else begin
      unique case (boot_state)
        BOOT_WAIT: begin
          // wait for the synchroniser to fill before trusting the strap
          settle_cnt <= settle_cnt + 3'h1;
          if (settle_cnt == STRAP_SETTLE_CYC) begin
            nibble_codec_bypass <= strap_sync;
            boot_state <= BOOT_RUN;
          end
        end
        BOOT_RUN: begin
          if (wr_acc && paddr == ADDR_LOOP_BYP) begin
            nibble_codec_bypass <= pwdata[CODEC_BYP_BIT];
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_integrity_flag <= 1'b0;
    end else begin
      carrier_integrity_flag <= cim_unstable_in;
    end
  end

  assign early_end_err = rx_nibble_valid_in && in_stream_in && idle_sym_in && idle_prev &&
                         !delim_seen && !end_delim_in;

  // stream tracking; cleared between streams
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_prev <= 1'b0;
      delim_seen <= 1'b0;
    end else if (!in_stream_in) begin
      idle_prev <= 1'b0;
      delim_seen <= 1'b0;
    end else if (rx_nibble_valid_in) begin
      idle_prev <= idle_sym_in;
      delim_seen <= delim_seen || end_delim_in;
    end
  end

  // substitute only on 100 Mb/s error nibbles; code errors win
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_out <= 4'h0;
      rx_er_out <= 1'b0;
      rx_valid_out <= 1'b0;
    end else begin
      rx_valid_out <= rx_nibble_valid_in;
      rx_er_out <= 1'b0;
      if (rx_nibble_valid_in) begin
        rx_er_out <= 1'b1;
        if (speed_100_in && code_err_in) begin
          rxd_out <= code_violation_select ? NIB_CODE : NIB_GENERIC;
        end else if (speed_100_in && early_end_err) begin
          rxd_out <= early_end_select ? NIB_EARLY : NIB_GENERIC;
        end else if (speed_100_in && link_err_in && link_fault_report) begin
          rxd_out <= NIB_LINK;
        end else if (speed_100_in && pkt_timeout_in && packet_timeout_report) begin
          rxd_out <= NIB_PKT;
        end else begin
          rxd_out <= rxd_in;
          rx_er_out <= 1'b0;
        end
      end
    end
  end

  // event sources for the interrupt status, one per reported error
  always_comb begin
    irq_events = '0;
    irq_events[IRQ_CODE] = rx_nibble_valid_in && speed_100_in && code_err_in;
    irq_events[IRQ_EARLY] = speed_100_in && early_end_err;
    irq_events[IRQ_LINK] = rx_nibble_valid_in && speed_100_in && link_err_in && link_fault_report;
    irq_events[IRQ_PKT] = rx_nibble_valid_in && speed_100_in && pkt_timeout_in && packet_timeout_report;
    irq_events[IRQ_CIM] = cim_unstable_in && !carrier_integrity_flag;
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= RST_IRQ;
      irq <= 1'b0;
    end else begin
      if (wr_acc && paddr == ADDR_IRQ_STAT) begin
        irq_status <= (irq_status & ~pwdata[IRQ_W-1:0]) | irq_events;
      end else begin
        irq_status <= irq_status | irq_events;
      end
      irq <= |(irq_status & irq_mask);
    end
  end

  // per-LED pulse stretcher; short activity blips stay visible to the eye
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LEDS; gi++) begin : g_led
      logic [STRETCH_W-1:0] hold_cnt;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          hold_cnt <= '0;
        end else if (led_status_in[gi]) begin
          hold_cnt <= STRETCH_W'(LED_STRETCH_CYC);
        end else if (hold_cnt != '0) begin
          hold_cnt <= hold_cnt - STRETCH_W'(1);
        end
      end
      assign led_drive[gi] = led_stretch_bypass ? led_status_in[gi] : (led_status_in[gi] || hold_cnt != '0);
    end
  endgenerate

  // indicator pins; select routes the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_indicator_pin <= 1'b0;
      rx_led_out <= 1'b0;
    end else begin
      if (indicator_select_field == SEL_CIM_A || indicator_select_field == SEL_CIM_B) begin
        transmit_indicator_pin <= carrier_integrity_flag;
      end else begin
        transmit_indicator_pin <= led_drive[0];
      end
      rx_led_out <= led_drive[1];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_cim_reset;
    $rose(presetn) |-> !carrier_integrity_flag;
  endproperty
  a_cim_reset: assert property (p_cim_reset) else $error("flag not clear after reset");

  property p_ind_cim;
    (indicator_select_field == SEL_CIM_A || indicator_select_field == SEL_CIM_B) ##1
      $stable(indicator_select_field) |=> transmit_indicator_pin == $past(carrier_integrity_flag);
  endproperty
  a_ind_cim: assert property (p_ind_cim) else $error("indicator not showing flag");

  property p_code_nib;
    rx_nibble_valid_in && speed_100_in && code_err_in |=>
      rx_er_out && rxd_out == ($past(code_violation_select) ? 4'h5 : 4'h6);
  endproperty
  a_code_nib: assert property (p_code_nib) else $error("wrong code error nibble");

  property p_early_nib;
    speed_100_in && early_end_err && !code_err_in |=>
      rx_er_out && rxd_out == ($past(early_end_select) ? 4'h4 : 4'h6);
  endproperty
  a_early_nib: assert property (p_early_nib) else $error("wrong premature end nibble");

  property p_two_idle;
    (rx_nibble_valid_in && in_stream_in && idle_sym_in && !end_delim_in && !delim_seen) ##1
      (!rx_nibble_valid_in && in_stream_in) ##1
      (rx_nibble_valid_in && in_stream_in && idle_sym_in && !end_delim_in && speed_100_in) |=> rx_er_out;
  endproperty
  a_two_idle: assert property (p_two_idle) else $error("idle pair not flagged");

  property p_link_nib;
    rx_nibble_valid_in && speed_100_in && link_err_in && !code_err_in && !early_end_err |=>
      ($past(link_fault_report) ? (rx_er_out && rxd_out == 4'h3) :
       ($past(pkt_timeout_in) ? 1'b1 : !rx_er_out && rxd_out == $past(rxd_in)));
  endproperty
  a_link_nib: assert property (p_link_nib) else $error("link error handling wrong");

  property p_pkt_nib;
    rx_nibble_valid_in && speed_100_in && pkt_timeout_in && !code_err_in && !early_end_err && !link_err_in |=>
      ($past(packet_timeout_report) ? rxd_out == 4'h2 : rxd_out == $past(rxd_in)) &&
      rx_er_out == $past(packet_timeout_report);
  endproperty
  a_pkt_nib: assert property (p_pkt_nib) else $error("timeout handling wrong");

  property p_rsvd_zero;
    psel && penable && pready && !pwrite && paddr == ADDR_LOOP_BYP |-> !prdata[15];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read nonzero");

  property p_led_bypass;
    led_stretch_bypass && $past(led_stretch_bypass) |=> rx_led_out == $past(led_status_in[1]);
  endproperty
  a_led_bypass: assert property (p_led_bypass) else $error("bypassed led not direct");

  property p_strap_load;
    boot_state == BOOT_WAIT && settle_cnt == STRAP_SETTLE_CYC |=> nibble_codec_bypass == $past(strap_sync);
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap not loaded");

  property p_no_sub_10;
    rx_nibble_valid_in && !speed_100_in |=> !rx_er_out && rxd_out == $past(rxd_in);
  endproperty
  a_no_sub_10: assert property (p_no_sub_10) else $error("substitution at 10 Mb/s");

  c_code_err: cover property (rx_nibble_valid_in && speed_100_in && code_err_in);
  c_early_end: cover property (early_end_err && speed_100_in);
  c_irq: cover property ($rose(irq));
  c_ind_cim: cover property (indicator_select_field == SEL_CIM_A && carrier_integrity_flag);
endmodule : pcer_top
`default_nettype wire

/* sim/pcer_mac_model.sv */
/*
  Receiving MAC on the MII receive path: it takes each nibble that the block
  marks valid and hands it on one cycle later, with the error line beside it.
  Assumes the block drives rxd, rx_er and rx_valid from pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pcer_mac_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] rxd,
  input wire logic rx_er,
  input wire logic rx_valid,
  output logic got,
  output logic [4:0] word
);
  // capture every cycle, got marks the words from valid strobes; rxd between strobes means nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      got <= 1'b0;
      word <= 5'h00;
    end else begin
      got <= rx_valid;
      word <= {rx_er, rxd};
    end
  end
endmodule : pcer_mac_model
`default_nettype wire

/* sim/tb_top.sv */
/*
  Self-checking bench of the receive error report block: APB register
  accesses, error nibble substitution, indicator, LED, strap and interrupt.
  Assumes the zero-wait APB slave and one-cycle receive latency of the design.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pcer_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, speed_100_in = 1'b1, rx_nibble_valid_in = 1'b0;
  logic [3:0] rxd_in = 4'h0, rxd_out, d, cfg;
  logic in_stream_in = 1'b0, idle_sym_in = 1'b0, end_delim_in = 1'b0, code_err_in = 1'b0;
  logic link_err_in = 1'b0, pkt_timeout_in = 1'b0, cim_unstable_in = 1'b0;
  logic [1:0] led_status_in = 2'h0;
  logic symbol_strap_pin = 1'b1, rx_er_out, rx_valid_out, transmit_indicator_pin;
  logic rx_led_out, nibble_codec_bypass, irq, got;
  logic [4:0] word;
  logic [32:0] rq[$];
  logic [4:0] nq[$];
  int n_fail = 0, comparisons = 0, cyc = 0, seed = 22028;

  pcer_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .speed_100_in(speed_100_in), .rx_nibble_valid_in(rx_nibble_valid_in), .rxd_in(rxd_in),
    .in_stream_in(in_stream_in), .idle_sym_in(idle_sym_in), .end_delim_in(end_delim_in),
    .code_err_in(code_err_in), .link_err_in(link_err_in), .pkt_timeout_in(pkt_timeout_in),
    .cim_unstable_in(cim_unstable_in), .led_status_in(led_status_in),
    .symbol_strap_pin(symbol_strap_pin), .rxd_out(rxd_out), .rx_er_out(rx_er_out),
    .rx_valid_out(rx_valid_out), .transmit_indicator_pin(transmit_indicator_pin),
    .rx_led_out(rx_led_out), .nibble_codec_bypass(nibble_codec_bypass), .irq(irq));

  pcer_mac_model i_mac (.pclk(pclk), .presetn(presetn), .rxd(rxd_out), .rx_er(rx_er_out),
    .rx_valid(rx_valid_out), .got(got), .word(word));

  // 200 MHz clock
  initial begin
    forever #2.5 pclk = ~pclk;
  end

  task automatic conclude;
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic bad(input string m);
    n_fail++;
    $display("wrong value at %0t: %s", $time, m);
  endtask : bad

  task automatic chk_bus(input logic [32:0] g, input logic [32:0] e);
    comparisons++;
    if (g !== e) bad($sformatf("bus got %h want %h", g, e));
  endtask : chk_bus

  task automatic chk_nib(input logic [4:0] g, input logic [4:0] e);
    comparisons++;
    if (g !== e) bad($sformatf("nibble got %h want %h", g, e));
  endtask : chk_nib

  task automatic chk_pin(input logic g, input logic e, input string m);
    comparisons++;
    if (g !== e) bad(m);
  endtask : chk_pin

  // one APB transfer; a read notes {pslverr, prdata} for the watcher
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    if (!w) rq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one strobed nibble; flags are {idle, delim, code, link, timeout}
  task automatic nib(input logic [3:0] v, input logic [4:0] f, input logic [4:0] e);
    @(posedge pclk);
    rx_nibble_valid_in <= 1'b1;
    rxd_in <= v;
    {idle_sym_in, end_delim_in, code_err_in, link_err_in, pkt_timeout_in} <= f;
    nq.push_back(e);
    @(posedge pclk);
    rx_nibble_valid_in <= 1'b0;
    {idle_sym_in, end_delim_in, code_err_in, link_err_in, pkt_timeout_in} <= 5'h00;
  endtask : nib

  // watcher: read data taken at the edge that ends the access phase
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (rq.size() == 0) bad("unexpected read");
      else chk_bus({pslverr, prdata}, rq.pop_front());
    end
    if (got) begin
      if (nq.size() == 0) bad("unexpected nibble");
      else chk_nib(word, nq.pop_front());
    end
  end

  // hang guard: far above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // strap lands at the 5th edge after release
    repeat (6) @(posedge pclk);
    chk_pin(nibble_codec_bypass, 1'b1, "strap not loaded");
    apb(1'b0, ADDR_PCS_CFG, 32'h0, 33'h0);
    apb(1'b0, ADDR_LOOP_BYP, 32'h0, 33'h000002000);
    apb(1'b0, 12'h000, 32'h0, 33'h100000000);
    apb(1'b1, ADDR_LOOP_BYP, 32'hffffffff, 33'h0);
    apb(1'b0, ADDR_LOOP_BYP, 32'h0, 33'h000006000);
    apb(1'b1, ADDR_LOOP_BYP, 32'h0, 33'h0);
    @(posedge pclk);
    chk_pin(nibble_codec_bypass, 1'b0, "codec bypass not written");
    // every combination of the four error controls
    for (int i = 0; i < 16; i++) begin
      cfg = i[3:0];
      d = 4'($random(seed));
      apb(1'b1, ADDR_PCS_CFG, {28'h0, cfg}, 33'h0);
      apb(1'b0, ADDR_PCS_CFG, 32'h0, {29'h0, cfg});
      nib(d, 5'b00100, {1'b1, (cfg[3] ? NIB_CODE : NIB_GENERIC)});
      @(posedge pclk);
      in_stream_in <= 1'b1;
      nib(d, 5'b10000, {1'b0, d});
      nib(d, 5'b10000, {1'b1, (cfg[2] ? NIB_EARLY : NIB_GENERIC)});
      @(posedge pclk);
      in_stream_in <= 1'b0;
      nib(d, 5'b00010, (cfg[1] ? {1'b1, NIB_LINK} : {1'b0, d}));
      nib(d, 5'b00001, (cfg[0] ? {1'b1, NIB_PKT} : {1'b0, d}));
    end
    // 10 Mb/s path: no substitution even on a code error
    @(posedge pclk);
    speed_100_in <= 1'b0;
    nib(d, 5'b00100, {1'b0, d});
    @(posedge pclk);
    speed_100_in <= 1'b1;
    // interrupt: masked, unmasked, cleared
    chk_pin(irq, 1'b0, "irq while masked");
    apb(1'b1, ADDR_IRQ_MASK, 32'h1, 33'h0);
    repeat (2) @(posedge pclk);
    chk_pin(irq, 1'b1, "irq not raised");
    apb(1'b1, ADDR_IRQ_STAT, 32'h1f, 33'h0);
    repeat (2) @(posedge pclk);
    chk_pin(irq, 1'b0, "irq not cleared");
    apb(1'b0, ADDR_IRQ_STAT, 32'h0, 33'h0);
    // carrier flag on the indicator pin, both select codes
    apb(1'b1, ADDR_PHY_CTL, 32'h100, 33'h0);
    cim_unstable_in <= 1'b1;
    repeat (4) @(posedge pclk);
    chk_pin(transmit_indicator_pin, 1'b1, "indicator not flag");
    apb(1'b0, ADDR_PCS_CFG, 32'h0, 33'h1f);
    apb(1'b1, ADDR_PHY_CTL, 32'h080, 33'h0);
    repeat (4) @(posedge pclk);
    chk_pin(transmit_indicator_pin, 1'b1, "indicator not flag on second code");
    cim_unstable_in <= 1'b0;
    repeat (4) @(posedge pclk);
    chk_pin(transmit_indicator_pin, 1'b0, "indicator stuck");
    // receive LED: stretched, then straight through
    led_status_in <= 2'h2;
    repeat (3) @(posedge pclk);
    led_status_in <= 2'h0;
    repeat (3) @(posedge pclk);
    chk_pin(rx_led_out, 1'b1, "led not stretched");
    apb(1'b1, ADDR_LOOP_BYP, 32'h4000, 33'h0);
    repeat (3) @(posedge pclk);
    chk_pin(rx_led_out, 1'b0, "led bypass ignored");
    apb(1'b0, ADDR_LOOP_BYP, 32'h0, 33'h000004000);
    repeat (3) @(posedge pclk);
    if (rq.size() != 0 || nq.size() != 0) bad("results missing");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
